// File: ir_stc_pkg.sv
// Shared constants, field layouts and state type of the serial control slave
package ir_stc_pkg;
  // Clock rate and gap timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int IDLE_GAP_NS = 10000;
  localparam int IDLE_GAP_CYCLES = (IDLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] GAP_LAST = 10'(IDLE_GAP_CYCLES - 1);
  // Synchronised pin positions
  localparam int PIN_COUNT = 3;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SERIAL_WRITE_DATA = 1;
  localparam int PIN_DET = 2;
  // First command byte fields
  localparam int SEL_LSB = 0;
  localparam int IDX_LSB = 3;
  localparam int OP_LSB = 6;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [2:0] IDX_EXTENDED = 3'h7;
  localparam logic [2:0] OWN_SELECT = 3'h0;
  // Register indices
  localparam logic [1:0] REG_POWER = 2'h0;
  localparam logic [1:0] REG_RATE = 2'h1;
  localparam logic [1:0] REG_TXPWR = 2'h2;
  localparam logic [1:0] REG_NONE = 2'h3;
  localparam logic [7:0] EXT_ID_INDEX = 8'h00;
  // Power state bits and reset values
  localparam int PWR_SHUTDOWN_BIT = 0;
  localparam int PWR_RX_OFF_BIT = 1;
  localparam int PWR_LED_OFF_BIT = 2;
  localparam logic [7:0] POWER_RESET = 8'h07;
  localparam logic [7:0] SLOW_INFRARED_RATE = 8'h00;
  localparam logic [7:0] MEDIUM_INFRARED_RATE = 8'h01;
  localparam logic [7:0] RATE_RESET = SLOW_INFRARED_RATE;
  localparam logic [7:0] TXPWR_RESET = 8'hff;
  // Framing counts
  localparam int INIT_CLOCKS = 30;
  localparam logic [4:0] INIT_LAST = 5'(INIT_CLOCKS - 1);
  localparam int END_CLOCKS = 3;
  localparam logic [1:0] END_LAST = 2'(END_CLOCKS - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Transaction states
  typedef enum logic [3:0] {
    ST_IDLE, ST_PENDING, ST_CMD_START, ST_CMD_BITS, ST_TURN, ST_RESP_START, ST_RESP_BITS, ST_END
  } stc_state_e;
endpackage

// File: pin_events_if.sv
// Synchronised pin levels and edge pulses
`timescale 1ns/10ps
`default_nettype none
interface pin_events_if;
  logic [ir_stc_pkg::PIN_COUNT-1:0] level;
  logic [ir_stc_pkg::PIN_COUNT-1:0] rise;
  logic [ir_stc_pkg::PIN_COUNT-1:0] fall;
  modport source (output level, rise, fall);
  modport sink (input level, rise, fall);
endinterface
`default_nettype wire

// File: pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Raw pins
  input wire logic [ir_stc_pkg::PIN_COUNT-1:0] pins_in,
  // Synchronised events
  pin_events_if.source ev
);
  logic [ir_stc_pkg::PIN_COUNT-1:0] ff1_reg;
  logic [ir_stc_pkg::PIN_COUNT-1:0] ff2_reg;
  logic [ir_stc_pkg::PIN_COUNT-1:0] ff3_reg;
  logic [ir_stc_pkg::PIN_COUNT-1:0] stable_reg;
  logic [ir_stc_pkg::PIN_COUNT-1:0] stable_next;
  logic [ir_stc_pkg::PIN_COUNT-1:0] rise_reg;
  logic [ir_stc_pkg::PIN_COUNT-1:0] rise_next;
  logic [ir_stc_pkg::PIN_COUNT-1:0] fall_reg;
  logic [ir_stc_pkg::PIN_COUNT-1:0] fall_next;

  genvar i;
  generate
    for (i = 0; i < ir_stc_pkg::PIN_COUNT; i++) begin : g_pin
      // Accept a new level once stages two and three agree
      always_comb begin
        stable_next[i] = (ff2_reg[i] == ff3_reg[i]) ? ff3_reg[i] : stable_reg[i];
        rise_next[i] = stable_next[i] & ~stable_reg[i];
        fall_next[i] = ~stable_next[i] & stable_reg[i];
      end
      // Register chain, first stage read only by the second
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          ff1_reg[i] <= 1'b0;
          ff2_reg[i] <= 1'b0;
          ff3_reg[i] <= 1'b0;
          stable_reg[i] <= 1'b0;
          rise_reg[i] <= 1'b0;
          fall_reg[i] <= 1'b0;
        end else begin
          ff1_reg[i] <= pins_in[i];
          ff2_reg[i] <= ff1_reg[i];
          ff3_reg[i] <= ff2_reg[i];
          stable_reg[i] <= stable_next[i];
          rise_reg[i] <= rise_next[i];
          fall_reg[i] <= fall_next[i];
        end
      end
    end
  endgenerate

  // Levels and pulses leave aligned
  assign ev.level = stable_reg;
  assign ev.rise = rise_reg;
  assign ev.fall = fall_reg;
endmodule
`default_nettype wire

// File: ir_stc_slave.sv
// Serial control slave of an infrared transceiver with its control registers
// Behaviour
// [R1] Control clock activity selects control or normal mode
// [R2] Shared pins carry infrared data or commands/responses
// [R3] Command phase always; response only when data returned
// [R4] Commands are two or three bytes long; a short read sends only one command byte here
// [R5] Decode operation type and transaction index fields
// [R6] Select field addresses transceiver; single system uses zero
// [R7] Second byte payload, or extended index then payload
// [R8] Write is command phase only, no response
// [R9] Read always followed by response with register contents
// [R10] Bits travel least significant first
// [R11] Bytes follow back to back without idle clocks
// [R12] Each byte preceded by one start clock
// [R13] Incoming data sampled on control clock rise
// [R14] Master changes write data on falling edge
// [R15] Slave changes read data on rising edge
// [R16] First rise disables LED; next rise starts
// [R17] LED re-enabled on final transaction clock
// [R18] Master keeps control clock idle between transactions
// [R19] Detector disabled during response phase
// [R20] Read: one low clock, then three end clocks
// [R21] Power-up defaults: shutdown, slow rate, full power
// [R22] Thirty clocks with data low enter control mode
// [R23] Extended index read returns identification code
// [R24] Index pattern tells payload from extended index
// [R25] Foreign select field: no change, no response
`timescale 1ns/10ps
`default_nettype none
module ir_stc_slave #(
  parameter logic [7:0] DEVICE_ID = 8'h5a // Arbitrary identification value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link pins from the controller and the optics
  input wire logic sclk_pin,
  input wire logic txd_pin,
  input wire logic detector_in,
  // Pin outputs
  output logic shared_read_data_pin,
  output logic led_drive,
  // Status
  output logic detector_enable,
  output logic control_ready,
  output logic [7:0] power_state_control,
  output logic [7:0] data_rate_mode,
  output logic [7:0] transmit_power_level
);
  pin_events_if pins ();

  ir_stc_pkg::stc_state_e state_reg, state_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [1:0] byte_cnt_reg, byte_cnt_next;
  logic [1:0] end_cnt_reg, end_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] ext_reg, ext_next;
  logic [7:0] resp_reg, resp_next;
  logic rd_bit_reg, rd_bit_next;
  logic ignore_reg, ignore_next;
  logic led_block_reg, led_block_next;
  logic [9:0] gap_cnt_reg, gap_cnt_next;
  logic [4:0] init_cnt_reg, init_cnt_next;
  logic ready_reg, ready_next;
  logic armed_reg, armed_next;
  logic [7:0] power_reg, power_next;
  logic [7:0] rate_reg, rate_next;
  logic [7:0] txpwr_reg, txpwr_next;
  logic led_reg, led_next;
  logic det_en_reg, det_en_next;
  logic rd_pin_reg, rd_pin_next;
  logic sclk_rise, sw_lvl, timeout, wr_en;
  logic [1:0] wr_idx;
  logic [7:0] shifted, wr_data, rd_value;

  // Pin synchroniser
  pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pins_in({detector_in, txd_pin, sclk_pin}),
    .ev(pins)
  );

  // Field decoders
  function automatic logic is_read(input logic [7:0] c);
    is_read = c[ir_stc_pkg::OP_LSB +: 2] == ir_stc_pkg::OP_READ;
  endfunction
  function automatic logic is_write(input logic [7:0] c);
    is_write = c[ir_stc_pkg::OP_LSB +: 2] == ir_stc_pkg::OP_WRITE;
  endfunction
  function automatic logic is_ext(input logic [7:0] c);
    is_ext = c[ir_stc_pkg::IDX_LSB +: 3] == ir_stc_pkg::IDX_EXTENDED;
  endfunction
  function automatic logic [1:0] reg_sel(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] k;
    k = is_ext(c) ? e : {5'h00, c[ir_stc_pkg::IDX_LSB +: 3]};
    reg_sel = (k < 8'h03) ? k[1:0] : ir_stc_pkg::REG_NONE;
  endfunction

  assign sclk_rise = pins.rise[ir_stc_pkg::PIN_SCLK];
  assign sw_lvl = pins.level[ir_stc_pkg::PIN_SERIAL_WRITE_DATA];
  assign timeout = gap_cnt_reg == ir_stc_pkg::GAP_LAST;
  // [R13] [R10] Sample write data on rise, LSB first
  assign shifted = {sw_lvl, shift_reg[7:1]};

  // Register read mux, extended index may fetch the identification code
  always_comb begin
    rd_value = 8'h00;
    // [R23] Identification code via extended index
    if (is_ext(cmd_reg) && ext_reg == ir_stc_pkg::EXT_ID_INDEX) begin
      rd_value = DEVICE_ID;
    end else begin
      case (reg_sel(cmd_reg, ext_reg))
        ir_stc_pkg::REG_POWER: rd_value = power_reg;
        ir_stc_pkg::REG_RATE: rd_value = rate_reg;
        ir_stc_pkg::REG_TXPWR: rd_value = txpwr_reg;
        default: rd_value = 8'h00;
      endcase
    end
  end

  // Transaction framing next state
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    end_cnt_next = end_cnt_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    ext_next = ext_reg;
    resp_next = resp_reg;
    rd_bit_next = rd_bit_reg;
    ignore_next = ignore_reg;
    led_block_next = led_block_reg;
    wr_en = 1'b0;
    wr_idx = ir_stc_pkg::REG_NONE;
    wr_data = shifted;
    // Gap timer restarts on any control clock edge
    if (pins.rise[ir_stc_pkg::PIN_SCLK] || pins.fall[ir_stc_pkg::PIN_SCLK]) begin
      gap_cnt_next = 10'h000;
    end else if (!timeout) begin
      gap_cnt_next = gap_cnt_reg + 10'h001;
    end else begin
      gap_cnt_next = gap_cnt_reg;
    end
    case (state_reg)
      ir_stc_pkg::ST_IDLE: begin
        rd_bit_next = 1'b1;
        // [R16] [R18] Any rise once armed marks a pending transaction, LED off
        if (armed_reg && sclk_rise) begin
          state_next = ir_stc_pkg::ST_PENDING;
          led_block_next = 1'b1;
        end
      end
      ir_stc_pkg::ST_PENDING: begin
        // [R16] [R12] Second rise is the start clock of byte one
        if (sclk_rise) begin
          state_next = ir_stc_pkg::ST_CMD_BITS;
          bit_cnt_next = 3'h0;
          byte_cnt_next = 2'h0;
        end
      end
      ir_stc_pkg::ST_CMD_START: begin
        // [R12] [R11] Start clock directly before each following byte
        if (sclk_rise) begin
          state_next = ir_stc_pkg::ST_CMD_BITS;
          bit_cnt_next = 3'h0;
        end
      end
      ir_stc_pkg::ST_CMD_BITS: begin
        if (sclk_rise) begin
          shift_next = shifted;
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == ir_stc_pkg::BIT_LAST) begin
            byte_cnt_next = byte_cnt_reg + 2'h1;
            state_next = ir_stc_pkg::ST_CMD_START;
            if (byte_cnt_reg == 2'h0) begin
              // [R5] [R6] [R25] Decode first byte, drop foreign select
              cmd_next = shifted;
              ignore_next = shifted[ir_stc_pkg::SEL_LSB +: 3] != ir_stc_pkg::OWN_SELECT;
              // [R4] [R24] Short read turns round after byte one
              if (is_read(shifted) && !is_ext(shifted)) begin
                state_next = ir_stc_pkg::ST_TURN;
              end
            end else if (byte_cnt_reg == 2'h1 && is_ext(cmd_reg)) begin
              // [R7] [R24] Second byte is the extended index
              ext_next = shifted;
              if (is_read(cmd_reg)) begin
                state_next = ir_stc_pkg::ST_TURN;
              end
            end else begin
              // [R8] [R7] Payload completes a write, no response
              wr_en = !ignore_reg && is_write(cmd_reg);
              wr_idx = reg_sel(cmd_reg, ext_reg);
              wr_data = shifted;
              state_next = ir_stc_pkg::ST_IDLE;
              // [R17] LED back on with the final clock
              led_block_next = 1'b0;
            end
          end
        end
      end
      ir_stc_pkg::ST_TURN: begin
        // [R20] [R9] One low clock, then the response follows
        if (sclk_rise) begin
          state_next = ir_stc_pkg::ST_RESP_START;
          resp_next = rd_value;
        end
      end
      ir_stc_pkg::ST_RESP_START: begin
        // [R15] [R10] Drive LSB on the rise closing the start clock
        if (sclk_rise) begin
          state_next = ir_stc_pkg::ST_RESP_BITS;
          bit_cnt_next = 3'h0;
          rd_bit_next = ignore_reg | resp_reg[0];
          resp_next = {1'b1, resp_reg[7:1]};
        end
      end
      ir_stc_pkg::ST_RESP_BITS: begin
        if (sclk_rise) begin
          bit_cnt_next = bit_cnt_reg + 3'h1;
          rd_bit_next = ignore_reg | resp_reg[0];
          resp_next = {1'b1, resp_reg[7:1]};
          if (bit_cnt_reg == ir_stc_pkg::BIT_LAST) begin
            state_next = ir_stc_pkg::ST_END;
            end_cnt_next = 2'h0;
            rd_bit_next = 1'b1;
          end
        end
      end
      ir_stc_pkg::ST_END: begin
        // [R20] [R17] Three end clocks, LED back on at the last
        if (sclk_rise) begin
          end_cnt_next = end_cnt_reg + 2'h1;
          if (end_cnt_reg == ir_stc_pkg::END_LAST) begin
            state_next = ir_stc_pkg::ST_IDLE;
            led_block_next = 1'b0;
          end
        end
      end
      default: begin
        state_next = ir_stc_pkg::ST_IDLE;
        led_block_next = 1'b0;
      end
    endcase
    // A stalled frame is abandoned so the optics come back
    if (state_reg != ir_stc_pkg::ST_IDLE && timeout) begin
      state_next = ir_stc_pkg::ST_IDLE;
      led_block_next = 1'b0;
      rd_bit_next = 1'b1;
    end
  end

  // Framing registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ir_stc_pkg::ST_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
      end_cnt_reg <= 2'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      ext_reg <= 8'h00;
      resp_reg <= 8'hff;
      rd_bit_reg <= 1'b1;
      ignore_reg <= 1'b0;
      led_block_reg <= 1'b0;
      gap_cnt_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      end_cnt_reg <= end_cnt_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      ext_reg <= ext_next;
      resp_reg <= resp_next;
      rd_bit_reg <= rd_bit_next;
      ignore_reg <= ignore_next;
      led_block_reg <= led_block_next;
      gap_cnt_reg <= gap_cnt_next;
    end
  end

  // Initialisation and control registers next state
  always_comb begin
    init_cnt_next = init_cnt_reg;
    ready_next = ready_reg;
    armed_next = armed_reg;
    power_next = power_reg;
    rate_next = rate_reg;
    txpwr_next = txpwr_reg;
    // [R22] Thirty rises with write data low make the slave ready
    if (!ready_reg && sclk_rise) begin
      if (sw_lvl) begin
        init_cnt_next = 5'h00;
      end else if (init_cnt_reg == ir_stc_pkg::INIT_LAST) begin
        ready_next = 1'b1;
      end else begin
        init_cnt_next = init_cnt_reg + 5'h01;
      end
    end
    // [R1] Frames are accepted after a quiet gap following init
    if (ready_reg && timeout) begin
      armed_next = 1'b1;
    end
    if (wr_en) begin
      case (wr_idx)
        ir_stc_pkg::REG_POWER: power_next = wr_data;
        ir_stc_pkg::REG_RATE: rate_next = wr_data;
        ir_stc_pkg::REG_TXPWR: txpwr_next = wr_data;
        default: power_next = power_reg;
      endcase
    end
  end

  // Initialisation and control registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      init_cnt_reg <= 5'h00;
      ready_reg <= 1'b0;
      armed_reg <= 1'b0;
      // [R21] Power-up defaults
      power_reg <= ir_stc_pkg::POWER_RESET;
      rate_reg <= ir_stc_pkg::RATE_RESET;
      txpwr_reg <= ir_stc_pkg::TXPWR_RESET;
    end else begin
      init_cnt_reg <= init_cnt_next;
      ready_reg <= ready_next;
      armed_reg <= armed_next;
      power_reg <= power_next;
      rate_reg <= rate_next;
      txpwr_reg <= txpwr_next;
    end
  end

  // Pin muxing between normal and control use
  always_comb begin
    // [R2] [R1] Normal mode passes infrared data; LED gated while framing
    led_next = !led_block_next && ready_reg && (state_next == ir_stc_pkg::ST_IDLE) &&
               !power_reg[ir_stc_pkg::PWR_LED_OFF_BIT] && !power_reg[ir_stc_pkg::PWR_SHUTDOWN_BIT] && sw_lvl;
    // [R19] Detector off during the response phase
    det_en_next = (state_next != ir_stc_pkg::ST_RESP_START) && (state_next != ir_stc_pkg::ST_RESP_BITS) &&
                  (state_next != ir_stc_pkg::ST_END) &&
                  !power_reg[ir_stc_pkg::PWR_SHUTDOWN_BIT] && !power_reg[ir_stc_pkg::PWR_RX_OFF_BIT];
    // [R2] [R3] Receive pin carries response bits in control mode
    if (state_next != ir_stc_pkg::ST_IDLE) begin
      rd_pin_next = rd_bit_next;
    end else begin
      rd_pin_next = det_en_next ? pins.level[ir_stc_pkg::PIN_DET] : 1'b1;
    end
  end

  // Output registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      led_reg <= 1'b0;
      det_en_reg <= 1'b0;
      rd_pin_reg <= 1'b1;
    end else begin
      led_reg <= led_next;
      det_en_reg <= det_en_next;
      rd_pin_reg <= rd_pin_next;
    end
  end

  assign led_drive = led_reg;
  assign detector_enable = det_en_reg;
  assign shared_read_data_pin = rd_pin_reg;
  assign control_ready = ready_reg;
  assign power_state_control = power_reg;
  assign data_rate_mode = rate_reg;
  assign transmit_power_level = txpwr_reg;

  // Checks
  sequence s_turn_rise;
    state_reg == ir_stc_pkg::ST_TURN && sclk_rise;
  endsequence
  sequence s_last_end_rise;
    state_reg == ir_stc_pkg::ST_END && sclk_rise && end_cnt_reg == ir_stc_pkg::END_LAST;
  endsequence

  a_led_off_pending: assert property (@(posedge clk) disable iff (reset) // [R16]
    (state_reg == ir_stc_pkg::ST_IDLE && armed_reg && sclk_rise) |=> ##1 !led_drive [*2])
    else $error("LED not disabled after pending rise");
  a_led_back_end: assert property (@(posedge clk) disable iff (reset) // [R17]
    s_last_end_rise |=> state_reg == ir_stc_pkg::ST_IDLE && !led_block_reg)
    else $error("LED block not released on final clock");
  a_detector_off_resp: assert property (@(posedge clk) disable iff (reset) // [R19]
    (state_reg == ir_stc_pkg::ST_RESP_BITS) |-> !detector_enable)
    else $error("Detector enabled during response");
  a_reset_defaults: assert property (@(posedge clk) disable iff (reset) // [R21]
    $past(reset) |-> power_state_control == ir_stc_pkg::POWER_RESET && data_rate_mode == ir_stc_pkg::RATE_RESET &&
    transmit_power_level == ir_stc_pkg::TXPWR_RESET)
    else $error("Control registers not at defaults after reset");
  a_write_silent: assert property (@(posedge clk) disable iff (reset) // [R8]
    (state_reg == ir_stc_pkg::ST_CMD_BITS || state_reg == ir_stc_pkg::ST_CMD_START) |-> shared_read_data_pin)
    else $error("Read pin driven low during command phase");
  a_resp_lsb_first: assert property (@(posedge clk) disable iff (reset) // [R10]
    (state_reg == ir_stc_pkg::ST_RESP_START && sclk_rise && !ignore_reg) |=> ##1 shared_read_data_pin == $past(resp_reg[0], 2))
    else $error("Response does not start with LSB");
  a_foreign_silent: assert property (@(posedge clk) disable iff (reset) // [R25]
    (ignore_reg && state_reg == ir_stc_pkg::ST_RESP_BITS) |-> shared_read_data_pin && !wr_en)
    else $error("Foreign command answered");
  a_init_thirty: assert property (@(posedge clk) disable iff (reset) // [R22]
    $rose(ready_reg) |-> $past(init_cnt_reg) == ir_stc_pkg::INIT_LAST && !$past(sw_lvl))
    else $error("Ready reached without thirty low clocks");
  a_read_responds: assert property (@(posedge clk) disable iff (reset) // [R9]
    s_turn_rise |=> state_reg == ir_stc_pkg::ST_RESP_START && resp_reg == $past(rd_value))
    else $error("Read not followed by response");
  a_rate_write: assert property (@(posedge clk) disable iff (reset) // [R7]
    (wr_en && wr_idx == ir_stc_pkg::REG_RATE) |=> data_rate_mode == $past(wr_data))
    else $error("Rate register not written");
  a_frame_gated: assert property (@(posedge clk) disable iff (reset) // [R1]
    (state_reg != ir_stc_pkg::ST_IDLE && state_next != ir_stc_pkg::ST_IDLE) |=> !led_drive)
    else $error("LED follows data during control mode");
endmodule
`default_nettype wire

// File: ir_stc_master.sv
// Behavioural serial master that drives the control link of the slave
`timescale 1ns/10ps
`default_nettype none
module ir_stc_master (
  // Link pins
  output logic sclk,
  output logic txd,
  input wire logic rdata
);
  logic in_frame;
  logic in_resp;
  logic txd_idle;
  // Clock stands low and data low until the bench starts traffic
  initial begin
    sclk = 1'b0;
    txd = 1'b0;
    in_frame = 1'b0;
    in_resp = 1'b0;
    txd_idle = 1'b0;
  end
  // Data changes at the fall, both sides sample at the rise
  task automatic clk_bit(input logic d, output logic q);
    sclk = 1'b0;
    txd = d;
    #62.5;
    sclk = 1'b1;
    q = rdata;
    #62.5;
  endtask
  // One start clock, then eight bits LSB first
  task automatic send_byte(input logic [7:0] b);
    logic q;
    clk_bit(1'b0, q);
    for (int i = 0; i < 8; i++) begin
      clk_bit(b[i], q);
    end
  endtask
  // Pending clock, then the first command byte
  task automatic open_frame(input logic [7:0] b1);
    logic q;
    clk_bit(1'b0, q);
    in_frame = 1'b1;
    send_byte(b1);
  endtask
  // Clock stays quiet longer than the slave's idle gap before the next frame
  task automatic close_frame();
    sclk = 1'b0;
    txd = txd_idle;
    in_frame = 1'b0;
    #12000;
  endtask
  task automatic init_clocks(input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      clk_bit(1'b0, q);
    end
    sclk = 1'b0;
  endtask
  task automatic write2(input logic [7:0] b1, input logic [7:0] b2);
    open_frame(b1);
    send_byte(b2);
    close_frame();
  endtask
  // Three-byte write: extended index, then payload
  task automatic write3(input logic [7:0] b1, input logic [7:0] idx, input logic [7:0] b3);
    open_frame(b1);
    send_byte(idx);
    send_byte(b3);
    close_frame();
  endtask
  // Level left on the data pin between frames
  task automatic set_idle(input logic v);
    txd_idle = v;
    txd = v;
  endtask
  // Read: turnaround, response start, bits, three end clocks
  task automatic read_reg(input logic [7:0] b1, input logic ext, input logic [7:0] idx, output logic [7:0] r);
    logic q;
    open_frame(b1);
    if (ext) begin
      send_byte(idx);
    end
    clk_bit(1'b0, q);
    clk_bit(1'b0, q);
    for (int i = 0; i < 11; i++) begin
      in_resp = (i > 1 && i < 8);
      clk_bit(i == 8 || i == 9, q);
      // Bit k was driven at the previous rise, taken here
      if (i < 8) begin
        r[i] = q;
      end
    end
    in_resp = 1'b0;
    close_frame();
  endtask
endmodule
`default_nettype wire

// File: tb_ir_stc_slave.sv
// Self-checking bench of the serial control slave
`timescale 1ns/10ps
`default_nettype none
module tb_ir_stc_slave;
  localparam logic [7:0] ID_VAL = 8'h5a; // Arbitrary identification value
  logic clk, reset, sclk, txd, detector_in, rd_pin, led_drive, det_en, ready;
  logic [7:0] pwr, rate, txpwr, rd;
  int err_count, samples_checked, led_hi, pin_lo, det_on;
  ir_stc_slave #(.DEVICE_ID(ID_VAL)) i_ir_stc_slave (.clk(clk), .reset(reset), .sclk_pin(sclk), .txd_pin(txd),
    .detector_in(detector_in), .shared_read_data_pin(rd_pin), .led_drive(led_drive), .detector_enable(det_en),
    .control_ready(ready), .power_state_control(pwr), .data_rate_mode(rate), .transmit_power_level(txpwr));
  ir_stc_master i_ir_stc_master (.sclk(sclk), .txd(txd), .rdata(rd_pin));
  // System clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watch LED, read pin and detector while frames run
  always @(negedge clk) begin
    if (i_ir_stc_master.in_frame && !sclk && led_drive !== 1'b0) led_hi++;
    if (i_ir_stc_master.in_frame && rd_pin !== 1'b1) pin_lo++;
    if (i_ir_stc_master.in_resp && det_en !== 1'b0) det_on++;
  end
  // Compare one byte-wide result
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    check8("power reg", 8'h07, pwr);
    check8("rate reg", 8'h00, rate);
    check8("txpwr reg", 8'hff, txpwr);
    check8("idle outputs", 8'h04, {4'h0, led_drive, rd_pin, ready, det_en});
    $display("Test reset done");
  endtask
  task automatic t_init();
    i_ir_stc_master.init_clocks(29);
    repeat (20) @(negedge clk);
    check8("ready after 29", 8'h00, {7'h00, ready});
    i_ir_stc_master.init_clocks(1);
    repeat (20) @(negedge clk);
    check8("ready after 30", 8'h01, {7'h00, ready});
    #12000;
    $display("Test init done");
  endtask
  task automatic t_write();
    pin_lo = 0;
    led_hi = 0;
    i_ir_stc_master.write2(8'h08, 8'h01);
    check8("rate write", 8'h01, rate);
    i_ir_stc_master.write2(8'h00, 8'h00);
    check8("power write", 8'h00, pwr);
    i_ir_stc_master.write2(8'h10, 8'hc3);
    check8("txpwr write", 8'hc3, txpwr);
    i_ir_stc_master.write3(8'h38, 8'h02, 8'h3c);
    check8("ext txpwr write", 8'h3c, txpwr);
    check8("pin low in write", 8'h00, 8'(pin_lo != 0));
    check8("led in frame", 8'h00, 8'(led_hi != 0));
    $display("Test write done");
  endtask
  task automatic t_read();
    det_on = 0;
    i_ir_stc_master.read_reg(8'h50, 1'b0, 8'h00, rd);
    check8("read txpwr", 8'h3c, rd);
    i_ir_stc_master.read_reg(8'h48, 1'b0, 8'h00, rd);
    check8("read rate", 8'h01, rd);
    // Stray light on the detector must not reach the response
    detector_in = 1'b0;
    repeat (10) @(negedge clk);
    check8("rx passthrough", 8'h00, {7'h00, rd_pin});
    i_ir_stc_master.read_reg(8'h78, 1'b1, 8'h00, rd);
    check8("read id", ID_VAL, rd);
    detector_in = 1'b1;
    check8("detector in response", 8'h00, 8'(det_on != 0));
    check8("detector idle", 8'h01, {7'h00, det_en});
    $display("Test read done");
  endtask
  task automatic t_foreign();
    i_ir_stc_master.write2(8'h09, 8'h00);
    check8("foreign write", 8'h01, rate);
    i_ir_stc_master.read_reg(8'h49, 1'b0, 8'h00, rd);
    check8("foreign read", 8'hff, rd);
    $display("Test foreign done");
  endtask
  task automatic t_led();
    led_hi = 0;
    i_ir_stc_master.set_idle(1'b1);
    repeat (20) @(negedge clk);
    check8("led normal mode", 8'h01, {7'h00, led_drive});
    i_ir_stc_master.write2(8'h10, 8'hff);
    check8("led in frame", 8'h00, 8'(led_hi != 0));
    check8("led after frame", 8'h01, {7'h00, led_drive});
    check8("txpwr full", 8'hff, txpwr);
    i_ir_stc_master.set_idle(1'b0);
    $display("Test led done");
  endtask
  // Main sequence and watchdog
  initial begin
    reset = 1'b1;
    detector_in = 1'b1;
    err_count = 0;
    samples_checked = 0;
    led_hi = 0;
    pin_lo = 0;
    det_on = 0;
    fork
      begin
        // About two and a half times the expected length of all tests
        #400000;
        err_count++;
        end_of_test();
      end
    join_none
    repeat (12) @(negedge clk);
    t_reset();
    reset = 1'b0;
    @(negedge clk);
    t_init();
    t_write();
    t_read();
    t_foreign();
    t_led();
    end_of_test();
  end
endmodule
`default_nettype wire
